// ===== src/bsp_cfg.svh
// Timing, geometry and message constants of the boot programming port
`ifndef BSP_CFG_SVH
`define BSP_CFG_SVH
// Clock and link timing
`define BSP_MCLK_NS        5
`define BSP_SCLK_MIN_NS    500
`define BSP_SCLK_HALF_CYC  ((`BSP_SCLK_MIN_NS+2*`BSP_MCLK_NS-1)/(2*`BSP_MCLK_NS))
`define BSP_RST_WAIT_MS    1
`define BSP_RST_WAIT_CYC   (`BSP_RST_WAIT_MS*1000000/`BSP_MCLK_NS)
`define BSP_BUSY_MIN_US    30
`define BSP_BUSY_CYC       ((`BSP_BUSY_MIN_US*1000+`BSP_MCLK_NS-1)/`BSP_MCLK_NS)
`define BSP_BOOT_CYC       16
// Flash geometry
`define BSP_PAGES          128
`define BSP_PAGE_BYTES     512
`define BSP_PAGE_WORDS     (`BSP_PAGE_BYTES/4)
`define BSP_SEG_BITS       32
`define BSP_MSG_SEGS       2
// Message words
`define BSP_HELLO_CMD      32'ha55aa54b
`define BSP_CMD_PREFIX     24'ha55aa5
`define BSP_OP_WRITE       8'h6e
`define BSP_INFO_RESP0     32'ha55aa58c
`define BSP_INFO_RESP1     32'h04010036
`define BSP_ACK_RESP0      32'ha55aa558
`define BSP_ACK_RESP1      32'h000100fe
`endif

// ===== src/bsp_pkg.sv
// Types for the two ends of the boot programming port, each used by one end only
package bsp_pkg;
    // Device sequencer states
    typedef enum {
        BSP_D_BOOT, BSP_D_RUN, BSP_D_INIT, BSP_D_IDLE, BSP_D_XFER, BSP_D_PROC
    } bsp_dev_st_t;
    // Host sequencer states
    typedef enum {
        BSP_H_IDLE, BSP_H_PGM, BSP_H_RST, BSP_H_REL, BSP_H_WRDY,
        BSP_H_READY, BSP_H_SHIFT, BSP_H_END, BSP_H_WAIT
    } bsp_host_st_t;
    // Response the device has queued
    typedef enum {BSP_RESP_INFO, BSP_RESP_ACK} bsp_resp_t;
endpackage : bsp_pkg

// ===== src/bsp_if.sv
// Pin bundle between programming host and device
`timescale 1ns/10ps
interface bsp_if;
    logic cs_n;            // Chip select, active low
    logic sclk;            // Serial clock from host
    logic mosi;            // Host to device data
    logic miso_o;          // Device data out
    logic miso_oe;         // Device drives miso
    logic miso;            // Resolved miso level
    logic busy_handshake;  // Low while device is busy
    logic reset_pin;       // Device reset, active high
    logic prog_o;          // Host program select value
    logic prog_oe;         // Host drives program select
    logic program_select;  // Resolved level, pulled down
    // Undriven miso reads low
    assign miso = miso_oe & miso_o;
    // Internal pull-down on program select
    assign program_select = prog_oe & prog_o;
    modport dev (input cs_n, sclk, mosi, reset_pin, program_select,
                 output miso_o, miso_oe, busy_handshake);
    modport host (output cs_n, sclk, mosi, reset_pin, prog_o, prog_oe,
                  input miso, busy_handshake);
endinterface : bsp_if

// ===== src/bsp_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module bsp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  logic mclk,
    input  logic rst,
    input  logic d,
    output logic q
);
    logic s1;  // Metastable stage, read only by s2
    logic s2;  // Second stage
    logic s3;  // Third stage
    ////////////////////////////////////////////////////////////////////////
    // Shift chain
    always_ff @(posedge mclk) begin
        s1 <= d;
        s2 <= s1;
        s3 <= s2;
    end
    // Output follows only once two settled stages agree
    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= RST_VAL;
        end else if (s2 == s3) begin
            q <= s3;
        end
    end
endmodule : bsp_sync

// ===== src/bsp_device.sv
// Device end: boot mode select, segment link and paged flash writer
`timescale 1ns/10ps
`include "bsp_cfg.svh"
// Overview of operation
// [R1] Flash of 128 pages, 512 bytes, whole-page writes
// [R2] Boot samples program select: program or runtime
// [R3] Device slave drives MISO only
// [R4] Chip select low selects a transfer
// [R5] Half duplex: MOSI or MISO, never both
// [R6] Bytes shifted most significant bit first
// [R7] Host keeps clock low when idle
// [R8] Device samples MOSI, changes MISO on rising
// [R9] Host changes MOSI, samples MISO on falling
// [R10] Host clock at most 2 MHz
// [R11] Busy line low busy, high ready
// [R12] Host reset and program select entry sequence
// [R13] Busy low during init, high when ready
// [R14] Four-byte segments, two per message
// [R15] Host never selects while device busy
// [R16] Busy pulses low after every segment
// [R17] Final segment busy pulse ends message
// [R18] Hello command gets fixed two-segment answer
// [R19] Undriven program select reads low: runtime
// [R20] Runtime mode runs flash code at once
// [R21] Busy low 30 us to 60 ms
// [R22] Deselected device ignores clock, MISO undriven
module bsp_device #(
    parameter int unsigned BUSY_CYCLES = `BSP_BUSY_CYC,
    parameter int unsigned INIT_CYCLES = `BSP_BUSY_CYC
) (
    input  logic        mclk,
    input  logic        rst,
    bsp_if.dev          lnk,
    input  logic [13:0] flash_addr,
    output logic [31:0] flash_rdata,
    output logic        app_run,
    output logic        prog_mode
);
    localparam int unsigned PW = `BSP_PAGE_WORDS;
    localparam int unsigned NW = `BSP_PAGES * `BSP_PAGE_WORDS;

    logic [31:0]          flash_mem [0:NW-1];  // Flash store
    logic [31:0]          page_buf  [0:PW-1];  // One page being assembled
    logic [31:0]          rx_shift;            // Link shift register
    logic [4:0]           bit_cnt;             // Bit within segment
    logic [31:0]          rx_word;             // Last full segment
    logic                 miso_q;              // Outgoing bit
    logic [31:0]          tx_word;             // Segment to send
    logic                 cs_s;                // Synced chip select
    logic                 cs_prev;             // Previous synced select
    logic                 rp_s;                // Synced reset pin
    logic                 ps_s;                // Synced program select
    logic                 core_rst;            // Local or pin reset
    bsp_pkg::bsp_dev_st_t st;                  // Sequencer state
    logic [31:0]          cnt;                 // Busy and boot timer
    logic                 tx_mode;             // Sending a response
    logic                 data_mode;           // Receiving page data
    logic                 data_next;           // Data phase after answer
    logic                 seg;                 // Segment within message
    logic [31:0]          cmd_hi;              // First command segment
    bsp_pkg::bsp_resp_t   resp;                // Queued response
    logic [7:0]           pages_left;          // Pages still to receive
    logic [6:0]           page;                // Page being filled
    logic [6:0]           wptr;                // Word within page
    logic                 copying;             // Page commit running
    logic [6:0]           cptr;                // Commit word index

    // Response word for a kind and segment
    function automatic logic [31:0] resp_word(bsp_pkg::bsp_resp_t r,
                                              logic s);
        if (r == bsp_pkg::BSP_RESP_INFO) begin
            resp_word = s ? `BSP_INFO_RESP1 : `BSP_INFO_RESP0;  // [R18]
        end else begin
            resp_word = s ? `BSP_ACK_RESP1 : `BSP_ACK_RESP0;
        end
    endfunction : resp_word

    ////////////////////////////////////////////////////////////////////////
    // Link clock domain. The clock only runs inside frames, so chip select
    // itself clears the bit counter between frames.
    always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
        if (lnk.cs_n) begin
            bit_cnt  <= 5'h00;                            // [R22]
            rx_shift <= 32'h0000_0000;
        end else begin
            rx_shift <= {rx_shift[30:0], lnk.mosi};       // [R8] [R6]
            bit_cnt  <= bit_cnt + 5'h01;
        end
    end
    // Capture the segment on its last rising edge; it stays put while
    // chip select is high, which is when the core reads it
    always_ff @(posedge lnk.sclk) begin
        if (bit_cnt == 5'h1f) begin
            rx_word <= {rx_shift[30:0], lnk.mosi};        // [R14]
        end
    end
    // Outgoing bit changes on rising edges, first bit is bit 31.
    // tx_word is held steady by the core whenever a frame may run.
    always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
        if (lnk.cs_n) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= tx_word[~bit_cnt];                  // [R8] [R6]
        end
    end
    assign lnk.miso_o  = miso_q;                          // [R3]
    // Drive only while selected and answering
    assign lnk.miso_oe = ~lnk.cs_n & tx_mode;             // [R4] [R5] [R22]

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    bsp_sync #(.RST_VAL(1'b1)) u_cs (
        .mclk (mclk), .rst (rst), .d (lnk.cs_n), .q (cs_s));
    bsp_sync #(.RST_VAL(1'b0)) u_rp (
        .mclk (mclk), .rst (rst), .d (lnk.reset_pin), .q (rp_s));
    bsp_sync #(.RST_VAL(1'b0)) u_ps (
        .mclk (mclk), .rst (rst), .d (lnk.program_select), .q (ps_s));
    assign core_rst = rst | rp_s;

    // Select edge tracking
    always_ff @(posedge mclk) begin
        if (core_rst) begin
            cs_prev <= 1'b1;
        end else begin
            cs_prev <= cs_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: boot, init, idle, transfer, processing
    always_ff @(posedge mclk) begin
        if (core_rst) begin
            st  <= bsp_pkg::BSP_D_BOOT;
            cnt <= 32'h0000_0000;
        end else begin
            case (st)
                bsp_pkg::BSP_D_BOOT: begin
                    // Boot code settles, then reads the select level
                    cnt <= cnt + 32'h1;
                    if (cnt == 32'(`BSP_BOOT_CYC - 1)) begin
                        cnt <= 32'h0000_0000;
                        st  <= ps_s ? bsp_pkg::BSP_D_INIT           // [R2]
                                    : bsp_pkg::BSP_D_RUN;   // [R19] [R20]
                    end
                end
                bsp_pkg::BSP_D_RUN: begin
                    st <= bsp_pkg::BSP_D_RUN;
                end
                bsp_pkg::BSP_D_INIT: begin
                    cnt <= cnt + 32'h1;
                    if (cnt == 32'(INIT_CYCLES - 1)) begin          // [R13]
                        st <= bsp_pkg::BSP_D_IDLE;
                    end
                end
                bsp_pkg::BSP_D_IDLE: begin
                    cnt <= 32'h0000_0000;
                    if (!cs_s && cs_prev) begin                     // [R4]
                        st <= bsp_pkg::BSP_D_XFER;
                    end
                end
                bsp_pkg::BSP_D_XFER: begin
                    if (cs_s && !cs_prev) begin                     // [R16]
                        st <= bsp_pkg::BSP_D_PROC;
                    end
                end
                bsp_pkg::BSP_D_PROC: begin
                    // Busy lasts the minimum time and any page commit
                    if (cnt != 32'(BUSY_CYCLES - 1)) begin
                        cnt <= cnt + 32'h1;
                    end else if (!copying) begin
                        st <= bsp_pkg::BSP_D_IDLE;          // [R16] [R17]
                    end
                end
                default: st <= bsp_pkg::BSP_D_BOOT;
            endcase
        end
    end

    // Mode outputs and busy line
    assign app_run   = (st == bsp_pkg::BSP_D_RUN);                  // [R20]
    assign prog_mode = (st == bsp_pkg::BSP_D_IDLE) ||
                       (st == bsp_pkg::BSP_D_XFER) ||
                       (st == bsp_pkg::BSP_D_PROC);
    // High when ready for a selection (idle) and through the transfer that follows
    assign lnk.busy_handshake = (st == bsp_pkg::BSP_D_IDLE) ||
                                (st == bsp_pkg::BSP_D_XFER);        // [R11]

    ////////////////////////////////////////////////////////////////////////
    // Message handling on each finished segment
    always_ff @(posedge mclk) begin
        if (core_rst) begin
            tx_mode    <= 1'b0;
            data_mode  <= 1'b0;
            data_next  <= 1'b0;
            seg        <= 1'b0;
            cmd_hi     <= 32'h0000_0000;
            resp       <= bsp_pkg::BSP_RESP_ACK;
            pages_left <= 8'h00;
            tx_word    <= 32'h0000_0000;
        end else if (st == bsp_pkg::BSP_D_XFER && cs_s && !cs_prev) begin
            if (tx_mode) begin
                // Second answer segment closes the message
                seg     <= ~seg;
                tx_word <= resp_word(resp, ~seg);
                if (seg) begin
                    tx_mode   <= 1'b0;                              // [R17]
                    data_mode <= data_next;
                    data_next <= 1'b0;
                end
            end else if (data_mode) begin
                // Last word of the last page ends the data phase
                if (wptr == 7'(PW - 1) && pages_left == 8'h01) begin
                    data_mode  <= 1'b0;
                    tx_mode    <= 1'b1;
                    resp       <= bsp_pkg::BSP_RESP_ACK;
                    tx_word    <= `BSP_ACK_RESP0;
                end
                if (wptr == 7'(PW - 1)) begin
                    pages_left <= pages_left - 8'h01;
                end
            end else if (!seg) begin
                cmd_hi <= rx_word;                                  // [R14]
                seg    <= 1'b1;
            end else begin
                seg     <= 1'b0;
                tx_mode <= 1'b1;
                if (cmd_hi == `BSP_HELLO_CMD) begin                 // [R18]
                    resp    <= bsp_pkg::BSP_RESP_INFO;
                    tx_word <= `BSP_INFO_RESP0;
                end else begin
                    resp    <= bsp_pkg::BSP_RESP_ACK;
                    tx_word <= `BSP_ACK_RESP0;
                    if (cmd_hi == {`BSP_CMD_PREFIX, `BSP_OP_WRITE} &&
                        rx_word[31:24] != 8'h00) begin
                        data_next  <= 1'b1;
                        pages_left <= rx_word[31:24];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Page assembly: words gather in a buffer and a page reaches flash
    // only when complete, so a broken download never leaves half pages
    always_ff @(posedge mclk) begin
        if (core_rst) begin
            wptr    <= 7'h00;
            page    <= 7'h00;
            copying <= 1'b0;
            cptr    <= 7'h00;
        end else begin
            if (st == bsp_pkg::BSP_D_XFER && cs_s && !cs_prev &&
                data_mode && !tx_mode) begin
                wptr <= wptr + 7'h01;
                if (wptr == 7'(PW - 1)) begin
                    copying <= 1'b1;                                // [R1]
                    cptr    <= 7'h00;
                end
            end
            if (copying) begin
                cptr <= cptr + 7'h01;
                if (cptr == 7'(PW - 1)) begin
                    copying <= 1'b0;
                    page    <= page + 7'h01;
                end
            end
        end
    end
    // Buffer write
    always_ff @(posedge mclk) begin
        if (st == bsp_pkg::BSP_D_XFER && cs_s && !cs_prev && data_mode &&
            !tx_mode) begin
            page_buf[wptr] <= rx_word;
        end
    end
    // Flash write during commit, read port for runtime fetch
    always_ff @(posedge mclk) begin
        if (copying) begin
            flash_mem[{page, cptr}] <= page_buf[cptr];              // [R1]
        end
        flash_rdata <= flash_mem[flash_addr];
    end
endmodule : bsp_device

// ===== src/bsp_host.sv
// Host end: boot sequencing and segment master
`timescale 1ns/10ps
`include "bsp_cfg.svh"
module bsp_host #(
    parameter int unsigned HALF_CYCLES = `BSP_SCLK_HALF_CYC,
    parameter int unsigned WAIT_CYCLES = `BSP_RST_WAIT_CYC
) (
    input  logic        mclk,
    input  logic        rst,
    bsp_if.host         lnk,
    input  logic        boot_req,
    input  logic        boot_prog,
    output logic        link_ready,
    input  logic        seg_valid,
    output logic        seg_ready,
    input  logic        seg_rd,
    input  logic [31:0] seg_wdata,
    output logic [31:0] seg_rdata,
    output logic        seg_done
);
    bsp_pkg::bsp_host_st_t st;     // Sequencer state
    logic [31:0]           cnt;    // Wait and half-period timer
    logic                  prog;   // Requested mode
    logic                  rd;     // Current segment is a read
    logic [31:0]           sh;     // Outgoing bits
    logic [31:0]           rsh;    // Incoming bits
    logic [4:0]            bits;   // Falling edges done
    logic                  miso_s; // Synced miso
    logic                  busy_s; // Synced busy line

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    bsp_sync #(.RST_VAL(1'b0)) u_mi (
        .mclk (mclk), .rst (rst), .d (lnk.miso), .q (miso_s));
    bsp_sync #(.RST_VAL(1'b0)) u_by (
        .mclk (mclk), .rst (rst), .d (lnk.busy_handshake), .q (busy_s));

    assign seg_ready  = (st == bsp_pkg::BSP_H_READY) & busy_s;   // [R15]
    assign link_ready = (st == bsp_pkg::BSP_H_READY);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer with clock divider
    always_ff @(posedge mclk) begin
        if (rst) begin
            st          <= bsp_pkg::BSP_H_IDLE;
            cnt         <= 32'h0000_0000;
            prog        <= 1'b0;
            rd          <= 1'b0;
            sh          <= 32'h0000_0000;
            rsh         <= 32'h0000_0000;
            bits        <= 5'h00;
            seg_rdata   <= 32'h0000_0000;
            seg_done    <= 1'b0;
            lnk.cs_n    <= 1'b1;
            lnk.sclk    <= 1'b0;
            lnk.mosi    <= 1'b0;
            lnk.reset_pin <= 1'b0;
            lnk.prog_o  <= 1'b0;
            lnk.prog_oe <= 1'b0;
        end else begin
            seg_done <= 1'b0;
            case (st)
                bsp_pkg::BSP_H_IDLE: begin
                    if (boot_req) begin
                        prog        <= boot_prog;
                        lnk.prog_o  <= boot_prog;                   // [R12]
                        lnk.prog_oe <= 1'b1;
                        st          <= bsp_pkg::BSP_H_PGM;
                    end
                end
                bsp_pkg::BSP_H_PGM: begin
                    lnk.reset_pin <= 1'b1;                          // [R12]
                    cnt           <= 32'h0000_0000;
                    st            <= bsp_pkg::BSP_H_RST;
                end
                bsp_pkg::BSP_H_RST: begin
                    cnt <= cnt + 32'h1;
                    if (cnt == 32'(WAIT_CYCLES - 1)) begin
                        lnk.reset_pin <= 1'b0;
                        cnt           <= 32'h0000_0000;
                        st            <= bsp_pkg::BSP_H_REL;
                    end
                end
                bsp_pkg::BSP_H_REL: begin
                    cnt <= cnt + 32'h1;
                    if (cnt == 32'(WAIT_CYCLES - 1)) begin
                        lnk.prog_o <= 1'b0;                         // [R12]
                        st <= prog ? bsp_pkg::BSP_H_WRDY
                                   : bsp_pkg::BSP_H_IDLE;
                    end
                end
                bsp_pkg::BSP_H_WRDY: begin
                    if (busy_s) begin                               // [R13]
                        st <= bsp_pkg::BSP_H_READY;
                    end
                end
                bsp_pkg::BSP_H_READY: begin
                    if (boot_req) begin
                        st <= bsp_pkg::BSP_H_IDLE;
                    end else if (seg_valid && busy_s) begin         // [R11]
                        rd       <= seg_rd;
                        sh       <= seg_wdata;
                        bits     <= 5'h00;
                        cnt      <= 32'h0000_0000;
                        lnk.cs_n <= 1'b0;                           // [R4]
                        lnk.mosi <= seg_rd ? 1'b0 : seg_wdata[31];  // [R5]
                        st       <= bsp_pkg::BSP_H_SHIFT;
                    end
                end
                bsp_pkg::BSP_H_SHIFT: begin
                    cnt <= cnt + 32'h1;
                    if (cnt == 32'(HALF_CYCLES - 1)) begin          // [R10]
                        cnt      <= 32'h0000_0000;
                        lnk.sclk <= ~lnk.sclk;
                        if (lnk.sclk) begin
                            // Falling edge: sample, then present next bit
                            rsh  <= {rsh[30:0], miso_s};            // [R9]
                            sh   <= {sh[30:0], 1'b0};
                            lnk.mosi <= rd ? 1'b0 : sh[30];         // [R6]
                            bits <= bits + 5'h01;
                            if (bits == 5'h1f) begin                // [R14]
                                lnk.cs_n <= 1'b1;
                                st       <= bsp_pkg::BSP_H_END;
                            end
                        end
                    end
                end
                bsp_pkg::BSP_H_END: begin
                    lnk.mosi <= 1'b0;
                    if (!busy_s) begin                              // [R16]
                        st <= bsp_pkg::BSP_H_WAIT;
                    end
                end
                bsp_pkg::BSP_H_WAIT: begin
                    if (busy_s) begin                       // [R17] [R21]
                        seg_rdata <= rsh;
                        seg_done  <= 1'b1;
                        st        <= bsp_pkg::BSP_H_READY;
                    end
                end
                default: st <= bsp_pkg::BSP_H_IDLE;
            endcase
        end
    end
endmodule : bsp_host

// ===== tb/bsp_chk.sv
// Assertions watching the pins of the boot programming link
`timescale 1ns/10ps
module bsp_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic busy_handshake,
    input wire logic prog_oe,
    input wire logic program_select
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_miso_sel_only: assert property (miso_oe |-> !cs_n)
        else $error("miso driven while deselected");
    a_half_duplex: assert property (miso_oe |-> !mosi)
        else $error("mosi active during answer");
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("clock high while idle");
    a_sclk_half_len: assert property (
        $changed(sclk) |=> $stable(sclk)[*3])
        else $error("serial clock phase too short");
    a_sel_when_ready: assert property (
        $fell(cs_n) |-> busy_handshake)
        else $error("selected while busy");
    a_busy_after_seg: assert property (
        $rose(cs_n) |-> ##[1:12] !busy_handshake)
        else $error("no busy pulse after segment");
    a_busy_low_hold: assert property (
        $fell(busy_handshake) |-> (!busy_handshake)[*8])
        else $error("busy pulse too short");
    a_miso_on_rise: assert property (
        !cs_n && miso_oe && $past(miso_oe) && $changed(miso_o)
        |-> $rose(sclk))
        else $error("miso moved off rising edge");
    a_prog_pulldown: assert property (!prog_oe |-> !program_select)
        else $error("undriven program select not low");
    // Main traffic seen
    cover property ($rose(miso_oe));
    cover property ($fell(cs_n));
    cover property ($fell(busy_handshake));
endmodule : bsp_chk

// ===== tb/test_boot_spi_programming_port.sv
// Self-checking bench joining host and device through the pin bundle
`timescale 1ns/10ps
module test_boot_spi_programming_port;
    logic        mclk = 0, rst = 1, boot_req = 0, boot_prog = 0;
    logic        seg_valid = 0, seg_rd = 0, link_ready, seg_ready, seg_done;
    logic        app_run, prog_mode;
    logic [31:0] seg_wdata = '0, seg_rdata, flash_rdata;
    logic [13:0] flash_addr = '0;
    int          bad_count = 0, total_checks = 0, n;
    always #2.5 mclk = ~mclk;
    bsp_if bsp_if_i ();
    // Short busy and reset waits keep the run brief; the half period
    // must outlast the host's miso synchroniser, so 5 is the floor here
    bsp_device #(.BUSY_CYCLES(20), .INIT_CYCLES(20)) bsp_device_i (.mclk(mclk),
        .rst(rst), .lnk(bsp_if_i.dev), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata), .app_run(app_run), .prog_mode(prog_mode));
    bsp_host #(.HALF_CYCLES(6), .WAIT_CYCLES(50)) bsp_host_i (.mclk(mclk),
        .rst(rst), .lnk(bsp_if_i.host), .boot_req(boot_req),
        .boot_prog(boot_prog), .link_ready(link_ready), .seg_valid(seg_valid),
        .seg_ready(seg_ready), .seg_rd(seg_rd), .seg_wdata(seg_wdata),
        .seg_rdata(seg_rdata), .seg_done(seg_done));
    bsp_chk bsp_chk_i (.mclk(mclk), .rst(rst), .cs_n(bsp_if_i.cs_n),
        .sclk(bsp_if_i.sclk), .mosi(bsp_if_i.mosi), .miso_o(bsp_if_i.miso_o),
        .miso_oe(bsp_if_i.miso_oe), .busy_handshake(bsp_if_i.busy_handshake),
        .prog_oe(bsp_if_i.prog_oe), .program_select(bsp_if_i.program_select));
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // A used-up wait counts as a mismatch and ends the run
    task automatic tmo;
        if (n >= 9000) begin
            chk(32'h0, 32'h1);
            results();
        end
    endtask : tmo
    // One segment, request pulsed for one cycle once the host is ready
    task automatic xfer(input logic rd, input logic [31:0] wd);
        n = 0;
        do @(posedge mclk); while (seg_ready !== 1'b1 && ++n < 9000);
        tmo();
        seg_valid <= 1'b1;
        seg_rd    <= rd;
        seg_wdata <= wd;
        @(posedge mclk);
        seg_valid <= 1'b0;
        n = 0;
        do @(posedge mclk); while (seg_done !== 1'b1 && ++n < 9000);
        tmo();
    endtask : xfer
    // Two command segments out, two answer segments back
    task automatic msg(input logic [31:0] c0, c1, e0, e1);
        xfer(1'b0, c0);
        xfer(1'b0, c1);
        xfer(1'b1, 32'h0);
        chk(seg_rdata, e0);
        xfer(1'b1, 32'h0);
        chk(seg_rdata, e1);
        $display("message test done");
    endtask : msg
    // One page of data after the write command, then the closing answer
    task automatic page_load;
        for (int i = 0; i < 128; i++) xfer(1'b0, 32'h3c000000 + 32'(i));
        xfer(1'b1, 32'h0);
        chk(seg_rdata, 32'ha55aa558);
        xfer(1'b1, 32'h0);
        chk(seg_rdata, 32'h000100fe);
        flash_addr <= 14'h07f;
        repeat (3) @(posedge mclk);
        chk(flash_rdata, 32'h3c00007f);
        $display("page test done");
    endtask : page_load
    // From ready the first request only returns the host to idle
    task automatic boot(input logic p);
        repeat (link_ready === 1'b1 ? 2 : 1) begin
            boot_req  <= 1'b1;
            boot_prog <= p;
            @(posedge mclk);
            boot_req  <= 1'b0;
            @(posedge mclk);
        end
        // Device first drops into reset, then comes up in the new mode;
        // a runtime host never reaches ready, so watch the device there
        n = 0;
        do @(posedge mclk); while (app_run !== 1'b0 && ++n < 9000);
        tmo();
        n = 0;
        do @(posedge mclk);
        while ((p ? link_ready : app_run) !== 1'b1 && ++n < 9000);
        tmo();
        repeat (60) @(posedge mclk);
        chk(app_run, !p);
        chk(prog_mode, p);
        chk(bsp_if_i.busy_handshake, p);
        $display("boot test done, mode %0d", p);
    endtask : boot
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        boot(1'b0);
        boot(1'b1);
        msg(32'ha55aa54b, 32'h000000f0, 32'ha55aa58c, 32'h04010036);
        msg(32'ha55aa56e, 32'h01000000, 32'ha55aa558, 32'h000100fe);
        page_load();
        results();
    end
endmodule : test_boot_spi_programming_port
